// File: cfrrc_defs.svh
// register offsets, field positions, reset values for the cfr reset/config bank
`ifndef CFRRC_DEFS_SVH
`define CFRRC_DEFS_SVH
`define CFRRC_OFS_RESET 12'h000
`define CFRRC_OFS_PLL 12'h004
`define CFRRC_OFS_CLK 12'h008
`define CFRRC_OFS_IO 12'h00C
`define CFRRC_OFS_CTRL 12'h010
`define CFRRC_OFS_DECIM 12'h014
`define CFRRC_OFS_RESMASK 12'h018
`define CFRRC_OFS_DLYMASK 12'h01C
`define CFRRC_OFS_SYNCSEL 12'h020
`define CFRRC_OFS_SWTRIG 12'h024
`define CFRRC_OFS_SYNCSTAT 12'h028
`define CFRRC_OFS_INTERP 12'h02C
`define CFRRC_OFS_GAIN_I 12'h030
`define CFRRC_OFS_GAIN_Q 12'h034
`define CFRRC_OFS_OFFS_I 12'h038
`define CFRRC_OFS_OFFS_Q 12'h03C
`define CFRRC_OFS_STAGE 12'h040
`define CFRRC_OFS_STAGE_END 12'h07C
`define CFRRC_OFS_COEF 12'h100
`define CFRRC_OFS_COEF_END 12'h1A0
`define CFRRC_RST_CFG 0
`define CFRRC_RST_DP 1
`define CFRRC_RST_CPLL 2
`define CFRRC_RST_OPLL 3
`define CFRRC_IO_IN_UNS 0
`define CFRRC_IO_OUT_UNS 1
`define CFRRC_IO_OE 2
`define CFRRC_CTRL_INTERP 4
`define CFRRC_CTRL_LIMIT 5
`define CFRRC_CLK_TWO_CH 4
`define CFRRC_RESET_RST 4'hF
`define CFRRC_PLL_RST 8'h00
`define CFRRC_GAIN_RST 16'h2000
`define CFRRC_OFFS_RST 16'h0000
`define CFRRC_CNT_MAX 16'h0008
`define CFRRC_NUM_COEF 40
`define CFRRC_NUM_STAGE 4
`define CFRRC_NUM_SYNC 8
`endif

// File: cfrrc_pkg.sv
// types for the cfr reset/config bank
package cfrrc_pkg;
  typedef enum logic [1:0] {
    CFRRC_SRC_OFF = 2'h0,
    CFRRC_SRC_A = 2'h1,
    CFRRC_SRC_B = 2'h2,
    CFRRC_SRC_SW = 2'h3
  } cfrrc_sync_src_t;
  typedef enum logic [1:0] {
    CFRRC_INT_BYPASS = 2'h0,
    CFRRC_INT_X2_CPLX = 2'h1,
    CFRRC_INT_X2_REAL = 2'h2,
    CFRRC_INT_X4_REAL = 2'h3
  } cfrrc_interp_t;
  typedef struct packed {
    logic [7:0] pll;
    logic [4:0] clk;
    logic [2:0] io;
    logic [5:0] ctrl;
    logic decim;
    logic [7:0] res_mask;
    logic [3:0] dly_mask;
    logic [15:0] sync_sel;
    logic [1:0] interp;
    logic [1:0][15:0] gain_sh;
    logic [1:0][15:0] offs_sh;
    logic [3:0][15:0] det;
    logic [3:0][15:0] tgt;
    logic [3:0][15:0] cnt;
    logic [39:0][15:0] coef;
    logic [39:0] coef_wr;
  } cfrrc_cfg_t;
  typedef struct packed {
    cfrrc_cfg_t cfg;
    logic [3:0] rst;
    logic [7:0] done;
    logic [1:0][15:0] gain_act;
    logic [1:0][15:0] offs_act;
    logic sw_evt;
    logic [3:0] dp_sync;
    logic [7:0] can_load;
    logic [3:0] dly_load;
    logic res_load;
    logic aw_got;
    logic w_got;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cfrrc_state_t;
endpackage

// File: cfrrc_reg_bank.sv
// reset, configuration and sync control register bank of the cfr processor
`timescale 1ns/1ns
`include "cfrrc_defs.svh"

module cfrrc_reg_bank
  import cfrrc_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // axi4-lite write address and data
  input wire logic [11:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read
  input wire logic [11:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // hardware sync inputs
  input wire logic sync_a_i,
  input wire logic sync_b_i,
  // resets to the rest of the chip
  output logic datapath_rst_o,
  output logic core_pll_rst_o,
  output logic out_pll_rst_o,
  output logic cfg_rst_o,
  // clock and io setup
  output logic [7:0] pll_ctrl_o,
  output logic [1:0] core_mult_o,
  output logic [1:0] out_mult_o,
  output logic two_channel_o,
  output logic [3:0] core_clk_per_sample_o,
  output logic in_unsigned_o,
  output logic out_unsigned_o,
  output logic out_pins_oe_o,
  // processing control
  output logic [3:0] stage_enable_o,
  output logic [3:0] stage_bypass_o,
  output logic interp_enable_o,
  output logic limiter_enable_o,
  output logic decim_by2_o,
  output cfrrc_interp_t interp_mode_o,
  // sync results
  output logic [3:0] dp_sync_o,
  output logic [7:0] canceler_load_o,
  output logic [3:0] delay_load_o,
  output logic resource_load_o,
  output logic datapath_ready_o,
  output logic ancillary_ready_o,
  // stage settings, output gain and offset, interpolator coefficients
  output logic [63:0] stage_detect_threshold_sq_o,
  output logic [63:0] stage_target_level_sq_o,
  output logic [63:0] stage_canceler_count_o,
  output logic [31:0] out_gain_o,
  output logic [31:0] out_offset_o,
  output logic [639:0] interp_coef_o
);

  // ************************************************************
  // state and helpers
  // ************************************************************
  cfrrc_state_t s_ff;
  cfrrc_state_t nxt_s;
  logic [7:0] fire;
  logic [31:0] rd;
  logic rd_ok;

  function automatic cfrrc_cfg_t cfg_init();
    cfrrc_cfg_t c;
    c = '0;
    c.pll = `CFRRC_PLL_RST;
    c.gain_sh = {2{`CFRRC_GAIN_RST}};
    c.offs_sh = {2{`CFRRC_OFFS_RST}};
    return c;
  endfunction

  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] dat,
    input logic [3:0] st
  );
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (st[b])
      begin
        r[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ************************************************************
  // sync event routing: each function has its own source select
  // ************************************************************
  always_comb
  begin
    for (int f = 0; f < `CFRRC_NUM_SYNC; f++)
    begin
      case (cfrrc_sync_src_t'(s_ff.cfg.sync_sel[2*f +: 2]))
        CFRRC_SRC_A: fire[f] = sync_a_i;
        CFRRC_SRC_B: fire[f] = sync_b_i;
        // datapath functions take no software event
        CFRRC_SRC_SW: fire[f] = (f >= 4) && s_ff.sw_evt;
        default: fire[f] = 1'b0;
      endcase
    end
  end

  // ************************************************************
  // read decode
  // ************************************************************
  always_comb
  begin
    logic [11:0] a;
    logic [11:0] off;
    a = {s_axi_araddr_i[11:2], 2'b00};
    off = 12'h000;
    rd = 32'h0000_0000;
    rd_ok = 1'b1;
    case (a)
      `CFRRC_OFS_RESET: rd[3:0] = s_ff.rst;
      `CFRRC_OFS_PLL: rd[7:0] = s_ff.cfg.pll;
      `CFRRC_OFS_CLK: rd[4:0] = s_ff.cfg.clk;
      `CFRRC_OFS_IO: rd[2:0] = s_ff.cfg.io;
      `CFRRC_OFS_CTRL: rd[5:0] = s_ff.cfg.ctrl;
      `CFRRC_OFS_DECIM: rd[0] = s_ff.cfg.decim;
      `CFRRC_OFS_RESMASK: rd[7:0] = s_ff.cfg.res_mask;
      `CFRRC_OFS_DLYMASK: rd[3:0] = s_ff.cfg.dly_mask;
      `CFRRC_OFS_SYNCSEL: rd[15:0] = s_ff.cfg.sync_sel;
      `CFRRC_OFS_SWTRIG: rd = 32'h0000_0000;
      `CFRRC_OFS_SYNCSTAT: rd[10:0] = {&s_ff.cfg.coef_wr,
        &s_ff.done[7:4], &s_ff.done[3:0], s_ff.done};
      `CFRRC_OFS_INTERP: rd[1:0] = s_ff.cfg.interp;
      `CFRRC_OFS_GAIN_I: rd[15:0] = s_ff.cfg.gain_sh[0];
      `CFRRC_OFS_GAIN_Q: rd[15:0] = s_ff.cfg.gain_sh[1];
      `CFRRC_OFS_OFFS_I: rd[15:0] = s_ff.cfg.offs_sh[0];
      `CFRRC_OFS_OFFS_Q: rd[15:0] = s_ff.cfg.offs_sh[1];
      default:
      begin
        if (a >= `CFRRC_OFS_STAGE && a < `CFRRC_OFS_STAGE_END)
        begin
          off = a - `CFRRC_OFS_STAGE;
          case (off[3:2])
            2'h0: rd[15:0] = s_ff.cfg.det[off[5:4]];
            2'h1: rd[15:0] = s_ff.cfg.tgt[off[5:4]];
            2'h2: rd[15:0] = s_ff.cfg.cnt[off[5:4]];
            default: rd_ok = 1'b0;
          endcase
        end
        else if (a >= `CFRRC_OFS_COEF && a < `CFRRC_OFS_COEF_END)
        begin
          off = a - `CFRRC_OFS_COEF;
          rd[15:0] = s_ff.cfg.coef[off[7:2]];
        end
        else
        begin
          rd_ok = 1'b0;
        end
      end
    endcase
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    logic [31:0] v;
    logic [11:0] off;
    logic ok;
    v = 32'h0000_0000;
    off = 12'h000;
    ok = 1'b1;
    nxt_s = s_ff;
    nxt_s.sw_evt = 1'b0;
    // write channels, taken in either order
    if (s_axi_awvalid_i && !s_ff.aw_got && !s_ff.bvalid)
    begin
      nxt_s.aw_got = 1'b1;
      nxt_s.awaddr = {s_axi_awaddr_i[11:2], 2'b00};
    end
    if (s_axi_wvalid_i && !s_ff.w_got && !s_ff.bvalid)
    begin
      nxt_s.w_got = 1'b1;
      nxt_s.wdata = s_axi_wdata_i;
      nxt_s.wstrb = s_axi_wstrb_i;
    end
    if (s_ff.aw_got && s_ff.w_got && !s_ff.bvalid)
    begin
      v = merge(32'h0000_0000, s_ff.wdata, s_ff.wstrb);
      if (s_ff.awaddr == `CFRRC_OFS_RESET)
      begin
        // reset bits stay writable so the host can leave config reset
        nxt_s.rst = 4'(merge({28'h0, s_ff.rst}, s_ff.wdata, s_ff.wstrb));
      end
      else if (!s_ff.rst[`CFRRC_RST_CFG])
      begin
        case (s_ff.awaddr)
          `CFRRC_OFS_PLL: nxt_s.cfg.pll = 8'(merge({24'h0, s_ff.cfg.pll},
            s_ff.wdata, s_ff.wstrb));
          `CFRRC_OFS_CLK: nxt_s.cfg.clk = 5'(merge({27'h0, s_ff.cfg.clk},
            s_ff.wdata, s_ff.wstrb));
          `CFRRC_OFS_IO: nxt_s.cfg.io = 3'(merge({29'h0, s_ff.cfg.io},
            s_ff.wdata, s_ff.wstrb));
          `CFRRC_OFS_CTRL: nxt_s.cfg.ctrl = 6'(merge({26'h0, s_ff.cfg.ctrl},
            s_ff.wdata, s_ff.wstrb));
          `CFRRC_OFS_DECIM: nxt_s.cfg.decim = s_ff.wstrb[0] ?
            s_ff.wdata[0] : s_ff.cfg.decim;
          `CFRRC_OFS_RESMASK: nxt_s.cfg.res_mask = s_ff.wstrb[0] ?
            s_ff.wdata[7:0] : s_ff.cfg.res_mask;
          `CFRRC_OFS_DLYMASK: nxt_s.cfg.dly_mask = s_ff.wstrb[0] ?
            s_ff.wdata[3:0] : s_ff.cfg.dly_mask;
          `CFRRC_OFS_SYNCSEL: nxt_s.cfg.sync_sel = 16'(merge(
            {16'h0, s_ff.cfg.sync_sel}, s_ff.wdata, s_ff.wstrb));
          `CFRRC_OFS_SWTRIG: nxt_s.sw_evt = v[0];
          `CFRRC_OFS_SYNCSTAT: nxt_s.sw_evt = 1'b0;
          `CFRRC_OFS_INTERP: nxt_s.cfg.interp = s_ff.wstrb[0] ?
            s_ff.wdata[1:0] : s_ff.cfg.interp;
          `CFRRC_OFS_GAIN_I: nxt_s.cfg.gain_sh[0] = 16'(merge(
            {16'h0, s_ff.cfg.gain_sh[0]}, s_ff.wdata, s_ff.wstrb));
          `CFRRC_OFS_GAIN_Q: nxt_s.cfg.gain_sh[1] = 16'(merge(
            {16'h0, s_ff.cfg.gain_sh[1]}, s_ff.wdata, s_ff.wstrb));
          `CFRRC_OFS_OFFS_I: nxt_s.cfg.offs_sh[0] = 16'(merge(
            {16'h0, s_ff.cfg.offs_sh[0]}, s_ff.wdata, s_ff.wstrb));
          `CFRRC_OFS_OFFS_Q: nxt_s.cfg.offs_sh[1] = 16'(merge(
            {16'h0, s_ff.cfg.offs_sh[1]}, s_ff.wdata, s_ff.wstrb));
          default:
          begin
            if (s_ff.awaddr >= `CFRRC_OFS_STAGE &&
                s_ff.awaddr < `CFRRC_OFS_STAGE_END)
            begin
              off = s_ff.awaddr - `CFRRC_OFS_STAGE;
              case (off[3:2])
                2'h0: nxt_s.cfg.det[off[5:4]] = 16'(merge(
                  {16'h0, s_ff.cfg.det[off[5:4]]},
                  s_ff.wdata, s_ff.wstrb));
                2'h1: nxt_s.cfg.tgt[off[5:4]] = 16'(merge(
                  {16'h0, s_ff.cfg.tgt[off[5:4]]},
                  s_ff.wdata, s_ff.wstrb));
                2'h2:
                begin
                  v = merge({16'h0, s_ff.cfg.cnt[off[5:4]]},
                    s_ff.wdata, s_ff.wstrb);
                  // counts above eight saturate
                  nxt_s.cfg.cnt[off[5:4]] = (v[15:0] > `CFRRC_CNT_MAX) ?
                    `CFRRC_CNT_MAX : v[15:0];
                end
                default: ok = 1'b0;
              endcase
            end
            else if (s_ff.awaddr >= `CFRRC_OFS_COEF &&
                     s_ff.awaddr < `CFRRC_OFS_COEF_END)
            begin
              off = s_ff.awaddr - `CFRRC_OFS_COEF;
              nxt_s.cfg.coef[off[7:2]] = 16'(merge(
                {16'h0, s_ff.cfg.coef[off[7:2]]},
                s_ff.wdata, s_ff.wstrb));
              nxt_s.cfg.coef_wr[off[7:2]] = 1'b1;
            end
            else
            begin
              ok = 1'b0;
            end
          end
        endcase
      end
      nxt_s.aw_got = 1'b0;
      nxt_s.w_got = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = ok ? 2'h0 : 2'h2;
    end
    if (s_ff.bvalid && s_axi_bready_i)
    begin
      nxt_s.bvalid = 1'b0;
    end
    // read channel: one read outstanding at a time
    if (s_axi_arvalid_i && !s_ff.rvalid)
    begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rdata = rd;
      nxt_s.rresp = rd_ok ? 2'h0 : 2'h2;
    end
    if (s_ff.rvalid && s_axi_rready_i)
    begin
      nxt_s.rvalid = 1'b0;
    end
    // sync events: one-cycle pulses registered for the datapath
    nxt_s.dp_sync = fire[3:0];
    nxt_s.dly_load = fire[4] ? s_ff.cfg.dly_mask : 4'h0;
    nxt_s.can_load = fire[5] ? s_ff.cfg.res_mask : 8'h00;
    nxt_s.res_load = fire[6];
    if (fire[7])
    begin
      // gains reach the output only at their sync
      nxt_s.gain_act = s_ff.cfg.gain_sh;
      nxt_s.offs_act = s_ff.cfg.offs_sh;
    end
    // datapath reset forgets syncs, but a same-cycle event still lands
    if (s_ff.rst[`CFRRC_RST_DP])
    begin
      nxt_s.done = 8'h00;
    end
    nxt_s.done = nxt_s.done | fire;
    // registers sit at reset values while config reset is held
    if (nxt_s.rst[`CFRRC_RST_CFG])
    begin
      nxt_s.cfg = cfg_init();
    end
    if (sys_rst_i)
    begin
      nxt_s = '0;
      nxt_s.cfg = cfg_init();
      nxt_s.rst = `CFRRC_RESET_RST;
      nxt_s.gain_act = {2{`CFRRC_GAIN_RST}};
      nxt_s.offs_act = {2{`CFRRC_OFFS_RST}};
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    s_ff <= nxt_s;
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign s_axi_awready_o = !s_ff.aw_got && !s_ff.bvalid;
  assign s_axi_wready_o = !s_ff.w_got && !s_ff.bvalid;
  assign s_axi_bvalid_o = s_ff.bvalid;
  assign s_axi_bresp_o = s_ff.bresp;
  assign s_axi_arready_o = !s_ff.rvalid;
  assign s_axi_rvalid_o = s_ff.rvalid;
  assign s_axi_rdata_o = s_ff.rdata;
  assign s_axi_rresp_o = s_ff.rresp;

  assign cfg_rst_o = s_ff.rst[`CFRRC_RST_CFG];
  assign datapath_rst_o = s_ff.rst[`CFRRC_RST_DP];
  assign core_pll_rst_o = s_ff.rst[`CFRRC_RST_CPLL];
  assign out_pll_rst_o = s_ff.rst[`CFRRC_RST_OPLL];

  assign pll_ctrl_o = s_ff.cfg.pll;
  assign core_mult_o = s_ff.cfg.clk[1:0];
  assign out_mult_o = s_ff.cfg.clk[3:2];
  assign two_channel_o = s_ff.cfg.clk[`CFRRC_CLK_TWO_CH];
  // core clocks per complex sample: four, or eight with two channels
  assign core_clk_per_sample_o = two_channel_o ? 4'h8 : 4'h4;
  assign in_unsigned_o = s_ff.cfg.io[`CFRRC_IO_IN_UNS];
  assign out_unsigned_o = s_ff.cfg.io[`CFRRC_IO_OUT_UNS];
  // enable bit resets low, so pins float through hardware reset
  assign out_pins_oe_o = s_ff.cfg.io[`CFRRC_IO_OE];

  assign stage_enable_o = s_ff.cfg.ctrl[3:0];
  assign stage_bypass_o = ~s_ff.cfg.ctrl[3:0];
  assign interp_enable_o = s_ff.cfg.ctrl[`CFRRC_CTRL_INTERP];
  assign limiter_enable_o = s_ff.cfg.ctrl[`CFRRC_CTRL_LIMIT];
  assign decim_by2_o = s_ff.cfg.decim;
  assign interp_mode_o = cfrrc_interp_t'(s_ff.cfg.interp);

  assign dp_sync_o = s_ff.dp_sync;
  assign canceler_load_o = s_ff.can_load;
  assign delay_load_o = s_ff.dly_load;
  assign resource_load_o = s_ff.res_load;
  assign datapath_ready_o = &s_ff.done[3:0];
  assign ancillary_ready_o = &s_ff.done[7:4];

  assign stage_detect_threshold_sq_o = s_ff.cfg.det;
  assign stage_target_level_sq_o = s_ff.cfg.tgt;
  assign stage_canceler_count_o = s_ff.cfg.cnt;
  assign out_gain_o = s_ff.gain_act;
  assign out_offset_o = s_ff.offs_act;
  assign interp_coef_o = s_ff.cfg.coef;

endmodule // cfrrc_reg_bank

// File: cfrrc_reg_bank_checker.sv
// concurrent checks on the ports of the cfr reset/config register bank
`timescale 1ns/1ns
module cfrrc_reg_bank_checker (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // hardware sync inputs
  input wire logic sync_a_i,
  input wire logic sync_b_i,
  // watched outputs
  input wire logic datapath_rst_o,
  input wire logic core_pll_rst_o,
  input wire logic out_pll_rst_o,
  input wire logic cfg_rst_o,
  input wire logic [7:0] pll_ctrl_o,
  input wire logic two_channel_o,
  input wire logic [3:0] core_clk_per_sample_o,
  input wire logic out_pins_oe_o,
  input wire logic [3:0] stage_enable_o,
  input wire logic [3:0] stage_bypass_o,
  input wire logic decim_by2_o,
  input wire logic [3:0] dp_sync_o,
  input wire logic datapath_ready_o,
  input wire logic [63:0] stage_canceler_count_o,
  input wire logic [31:0] out_gain_o,
  input wire logic [31:0] out_offset_o
);
  // ***
  // properties
  // ***
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_rst_out;
    $fell(sys_rst_i) |-> cfg_rst_o && datapath_rst_o && core_pll_rst_o && out_pll_rst_o
      && !out_pins_oe_o;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("reset outputs not set");
  property p_gain_rst;
    $fell(sys_rst_i) |-> out_gain_o == 32'h20002000 && out_offset_o == 32'h00000000;
  endproperty
  a_gain_rst: assert property (p_gain_rst) else $error("gain default wrong");
  // outputs must stay at defaults while the register reset is on
  property p_cfg_held;
    cfg_rst_o |-> pll_ctrl_o == 8'h00 && stage_enable_o == 4'h0 && !decim_by2_o && !out_pins_oe_o;
  endproperty
  a_cfg_held: assert property (p_cfg_held) else $error("config moved under reset");
  property p_bypass;
    stage_bypass_o == ~stage_enable_o;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass not inverse of enable");
  property p_rate;
    core_clk_per_sample_o == (two_channel_o ? 4'h8 : 4'h4);
  endproperty
  a_rate: assert property (p_rate) else $error("clocks per sample wrong");
  property p_cnt;
    stage_canceler_count_o[15:0] <= 16'h0008 && stage_canceler_count_o[31:16] <= 16'h0008
      && stage_canceler_count_o[47:32] <= 16'h0008 && stage_canceler_count_o[63:48] <= 16'h0008;
  endproperty
  a_cnt: assert property (p_cnt) else $error("canceler count above eight");
  property p_dp_hw;
    dp_sync_o != 4'h0 |-> $past(sync_a_i) || $past(sync_b_i);
  endproperty
  a_dp_hw: assert property (p_dp_hw) else $error("datapath sync without pin event");
  property p_dp_ready;
    $rose(datapath_ready_o) |-> dp_sync_o != 4'h0;
  endproperty
  a_dp_ready: assert property (p_dp_ready) else $error("ready without sync pulse");
endmodule // cfrrc_reg_bank_checker

bind cfrrc_reg_bank cfrrc_reg_bank_checker i_cfrrc_reg_bank_checker (.core_clk_i, .sys_rst_i,
  .sync_a_i, .sync_b_i, .datapath_rst_o, .core_pll_rst_o, .out_pll_rst_o, .cfg_rst_o, .pll_ctrl_o,
  .two_channel_o, .core_clk_per_sample_o, .out_pins_oe_o, .stage_enable_o, .stage_bypass_o,
  .decim_by2_o, .dp_sync_o, .datapath_ready_o, .stage_canceler_count_o, .out_gain_o, .out_offset_o);

// File: cfrrc_host_model.sv
// axi4-lite host model that programs the cfr register bank
`timescale 1ns/1ns
module cfrrc_host_model (
  // clock
  input wire logic clk_i,
  // write channels
  output logic [11:0] awaddr_o,
  output logic awvalid_o,
  input wire logic awready_i,
  output logic [31:0] wdata_o,
  output logic [3:0] wstrb_o,
  output logic wvalid_o,
  input wire logic wready_i,
  input wire logic [1:0] bresp_i,
  input wire logic bvalid_i,
  output logic bready_o,
  // read channels
  output logic [11:0] araddr_o,
  output logic arvalid_o,
  input wire logic arready_i,
  input wire logic [31:0] rdata_i,
  input wire logic [1:0] rresp_i,
  input wire logic rvalid_i,
  output logic rready_o
);
  // ***
  // bus tasks
  // ***
  initial
  begin
    {awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o} = 5'h00;
    {awaddr_o, araddr_o, wdata_o} = 56'h0;
    wstrb_o = 4'hF;
  end
  // answers are sampled mid-cycle, where they are settled
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic aw, w, b;
    r = 2'h3;
    @(posedge clk_i);
    {awaddr_o, wdata_o, awvalid_o, wvalid_o, bready_o} <= {a, d, 3'h7};
    for (n = 0; n < 200; n++)
    begin
      @(negedge clk_i);
      {aw, w, b} = {awvalid_o & awready_i, wvalid_o & wready_i, bvalid_i};
      if (b)
        r = bresp_i;
      @(posedge clk_i);
      // released lines show the inverse so stale values never look valid
      if (aw)
        {awvalid_o, awaddr_o} <= {1'b0, ~a};
      if (w)
        {wvalid_o, wdata_o} <= {1'b0, ~d};
      if (b)
        break;
    end
    bready_o <= 1'b0;
    @(negedge clk_i);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ar, v;
    {r, d} = {2'h3, 32'h0};
    @(posedge clk_i);
    {araddr_o, arvalid_o, rready_o} <= {a, 2'h3};
    for (n = 0; n < 200; n++)
    begin
      @(negedge clk_i);
      {ar, v} = {arvalid_o & arready_i, rvalid_i};
      if (v)
        {d, r} = {rdata_i, rresp_i};
      @(posedge clk_i);
      if (ar)
        {arvalid_o, araddr_o} <= {1'b0, ~a};
      if (v)
        break;
    end
    rready_o <= 1'b0;
    @(negedge clk_i);
  endtask
endmodule // cfrrc_host_model

// File: tb.sv
// self-checking bench for the cfr reset/config register bank
`timescale 1ns/1ns
module tb;
  import cfrrc_pkg::*;
  logic core_clk_i, sys_rst_i, sync_a_i, sync_b_i;
  logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o;
  logic s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
  logic [11:0] s_axi_awaddr_i, s_axi_araddr_i, a;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, out_gain_o, out_offset_o, v, e;
  logic [3:0] s_axi_wstrb_i, stage_enable_o, stage_bypass_o, dp_sync_o, delay_load_o;
  logic [3:0] core_clk_per_sample_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, core_mult_o, out_mult_o;
  logic datapath_rst_o, core_pll_rst_o, out_pll_rst_o, cfg_rst_o, two_channel_o;
  logic in_unsigned_o, out_unsigned_o, out_pins_oe_o, interp_enable_o, limiter_enable_o;
  logic decim_by2_o, resource_load_o, datapath_ready_o, ancillary_ready_o;
  logic [7:0] pll_ctrl_o, canceler_load_o;
  logic [63:0] stage_detect_threshold_sq_o, stage_target_level_sq_o, stage_canceler_count_o;
  logic [639:0] interp_coef_o;
  cfrrc_interp_t interp_mode_o;
  logic [3:0] cap_dp = 4'h0, cap_dly = 4'h0;
  logic [7:0] cap_can = 8'h00;
  logic cap_res = 1'b0;
  logic [31:0] m[int];
  logic [31:0] c[40];
  logic [31:0] g[4];
  logic [11:0] cfg_adr[8] = '{12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h018, 12'h01C,
    12'h02C};
  logic [31:0] cfg_msk[8] = '{32'hFF, 32'h1F, 32'h7, 32'h3F, 32'h1, 32'hFF, 32'hF, 32'h3};
  int i, seed, num_errors = 0, n_tests = 0;
  // every bench signal carries the name of the design port it meets
  cfrrc_reg_bank i_cfrrc_reg_bank (.*);
  cfrrc_host_model i_cfrrc_host_model (.clk_i(core_clk_i), .awaddr_o(s_axi_awaddr_i),
    .awvalid_o(s_axi_awvalid_i), .awready_i(s_axi_awready_o), .wdata_o(s_axi_wdata_i),
    .wstrb_o(s_axi_wstrb_i), .wvalid_o(s_axi_wvalid_i), .wready_i(s_axi_wready_o),
    .bresp_i(s_axi_bresp_o), .bvalid_i(s_axi_bvalid_o), .bready_o(s_axi_bready_i),
    .araddr_o(s_axi_araddr_i), .arvalid_o(s_axi_arvalid_i), .arready_i(s_axi_arready_o),
    .rdata_i(s_axi_rdata_o), .rresp_i(s_axi_rresp_o), .rvalid_i(s_axi_rvalid_o),
    .rready_o(s_axi_rready_i));
  // ***
  // helpers
  // ***
  always #2 core_clk_i = ~core_clk_i;
  // sticky copies of one-cycle pulses
  always @(posedge core_clk_i)
  begin
    if (!sys_rst_i)
    begin
      cap_dp <= cap_dp | dp_sync_o;
      cap_can <= cap_can | canceler_load_o;
      cap_dly <= cap_dly | delay_load_o;
      cap_res <= cap_res | resource_load_o;
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic w(input logic [11:0] ad, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    i_cfrrc_host_model.wr(ad, d, r);
    check(r, er);
  endtask
  task automatic rc(input logic [11:0] ad, input logic [31:0] ex, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    i_cfrrc_host_model.rd(ad, d, r);
    check(d, ex);
    check(r, er);
  endtask
  task automatic pulse(input logic b);
    @(posedge core_clk_i);
    {sync_b_i, sync_a_i} <= b ? 2'h2 : 2'h1;
    @(posedge core_clk_i);
    {sync_b_i, sync_a_i} <= 2'h0;
    repeat (2) @(negedge core_clk_i);
  endtask
  function automatic logic [31:0] obs(input logic [11:0] ad);
    int s;
    s = int'((ad - 12'h040) >> 4);
    case (ad)
      12'h004: obs = pll_ctrl_o;
      12'h008: obs = {two_channel_o, out_mult_o, core_mult_o};
      12'h00C: obs = {out_pins_oe_o, out_unsigned_o, in_unsigned_o};
      12'h010: obs = {limiter_enable_o, interp_enable_o, stage_enable_o};
      12'h014: obs = decim_by2_o;
      12'h02C: obs = interp_mode_o;
      default: obs = ad[3] ? stage_canceler_count_o[16*s+:16] : ad[2] ?
        stage_target_level_sq_o[16*s+:16] : stage_detect_threshold_sq_o[16*s+:16];
    endcase
  endfunction
  // ***
  // main sequence
  // ***
  initial
  begin
    repeat (20000) @(posedge core_clk_i);
    num_errors++;
    conclude();
  end
  initial
  begin
    seed = 32'h6640B4B8;
    {core_clk_i, sync_a_i, sync_b_i} = 3'h0;
    sys_rst_i = 1'b1;
    repeat (5) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    @(negedge core_clk_i);
    check({cfg_rst_o, datapath_rst_o, core_pll_rst_o, out_pll_rst_o, out_pins_oe_o}, 5'h1E);
    rc(12'h000, 32'hF, 2'h0);
    rc(12'h030, 32'h2000, 2'h0);
    w(12'h010, 32'h3F, 2'h0);
    rc(12'h010, 32'h0, 2'h0);
    w(12'h000, 32'hE, 2'h0);
    w(12'h004, 32'h5A, 2'h0);
    w(12'h008, 32'h0A, 2'h0);
    // warm-up shortened: the real wait is far beyond this run
    repeat (50) @(posedge core_clk_i);
    for (i = 3; i >= 0; i--)
    begin
      v = (i == 0) ? 32'h0 : 32'h1 << i;
      w(12'h000, v, 2'h0);
      check({out_pll_rst_o, core_pll_rst_o, datapath_rst_o, cfg_rst_o}, v);
    end
    // config registers other than pll and clk (written above) sit at zero once config reset is left
    foreach (cfg_adr[k]) m[cfg_adr[k]] = 32'h0;
    for (i = 0; i < 32; i++)
    begin
      a = cfg_adr[i % 8];
      v = $random(seed);
      v[1:0] = i[4:3];
      w(a, v, 2'h0);
      m[a] = v & cfg_msk[i % 8];
      rc(a, m[a], 2'h0);
      if (a < 12'h018 || a == 12'h02C)
        check(obs(a), m[a]);
      check(stage_bypass_o, 4'(~m[12'h010][3:0]));
    end
    check(core_clk_per_sample_o, m[12'h008][4] ? 32'h8 : 32'h4);
    for (i = 0; i < 12; i++)
    begin
      a = 12'h040 + 12'(16 * (i / 3) + 4 * (i % 3));
      v = (i % 3 == 2) ? 32'(7 + i / 3) : $random(seed) & 32'hFFFF;
      w(a, v, 2'h0);
      e = (i % 3 == 2 && v > 8) ? 32'h8 : v;
      rc(a, e, 2'h0);
      check(obs(a), e);
    end
    // hole between stage blocks
    w(12'h04C, 32'h5A5A, 2'h2);
    rc(12'h04C, 32'h0, 2'h2);
    for (i = 0; i < 40; i++)
    begin
      c[i] = $random(seed);
      w(12'h100 + 12'(4 * i), c[i], 2'h0);
    end
    rc(12'h028, 32'h400, 2'h0);
    for (i = 0; i < 40; i++)
      check(interp_coef_o[16*i+:16], c[i][15:0]);
    w(12'h018, 32'hA5, 2'h0);
    w(12'h01C, 32'h6, 2'h0);
    w(12'h020, 32'hFF95, 2'h0);
    for (i = 0; i < 4; i++)
    begin
      g[i] = $random(seed) & 32'hFFFF;
      w(12'h030 + 12'(4 * i), g[i], 2'h0);
    end
    check(out_gain_o, 32'h20002000);
    w(12'h024, 32'h1, 2'h0);
    repeat (3) @(negedge core_clk_i);
    check(cap_can, 8'hA5);
    check(cap_dly, 4'h6);
    check(cap_res, 1'b1);
    check(out_gain_o, {g[1][15:0], g[0][15:0]});
    check(out_offset_o, {g[3][15:0], g[2][15:0]});
    check({datapath_ready_o, ancillary_ready_o, cap_dp}, 6'h10);
    pulse(1'b0);
    check({datapath_ready_o, cap_dp}, 5'h07);
    pulse(1'b1);
    check({datapath_ready_o, cap_dp}, 5'h1F);
    w(12'h000, 32'h2, 2'h0);
    check({datapath_rst_o, datapath_ready_o}, 2'h2);
    conclude();
  end
endmodule // tb
